/* design/ddc_edid_slave.sv */
module ddc_edid_slave
  import ddc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic      [15:0] memAddr,
  output logic      [7:0]  memWdata,
  output logic             memWe,
  output logic             memRe,
  input  wire logic [7:0]  memRdata,
  output logic             cpuStall,
  output logic             endOfDataIrq
);

  // ****************************************************************
  // bus line conditioning
  // ****************************************************************
  logic sclLvl, sdaLvl, sclRise, sclFall, startDet, stopDet;

  ddc_line_sync ddc_line_sync_i (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sclLvl   (sclLvl),
    .sdaLvl   (sdaLvl),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .startDet (startDet),
    .stopDet  (stopDet)
  );

  // ****************************************************************
  // wishbone register file
  // ****************************************************************
  logic        enable_q, enable_d, wp_q, wp_d, ede_q, ede_d, eod_q, eod_d;
  logic [2:0]  cfg_q, cfg_d;
  logic [7:0]  ptrHigh_q, ptrHigh_d;
  logic        wbAck_q, wbAck_d;
  logic [31:0] wbDat_q, wbDat_d;
  logic        wbReq, wbWr;
  logic        hostMode_q, hostMode_d;
  logic [7:0]  ptrLow_q, ptrLow_d;
  ddc_state_e  state_q, state_d;
  logic        memWe_q, memWe_d, is256_q, is256_d;
  logic [15:0] memAddr_q, memAddr_d;
  logic        lastByte;

  assign wbReq    = wb_cyc_i & wb_stb_i & ~wbAck_q;
  assign wbWr     = wbReq & wb_we_i & wb_sel_i[0];
  assign lastByte = is256_q ? (memAddr_q[7:0] == 8'hff) : (memAddr_q[6:0] == 7'h7f);

  // one-cycle ack, unmapped addresses read zero and ignore writes
  always_comb begin
    enable_d  = enable_q;
    cfg_d     = cfg_q;
    wp_d      = wp_q;
    ede_d     = ede_q;
    ptrHigh_d = ptrHigh_q;
    eod_d     = eod_q;
    wbAck_d   = wbReq;
    wbDat_d   = 32'h0000_0000;
    if (wbWr && wb_adr_i == ADR_CTRL) begin
      enable_d = wb_dat_i[CTRL_EN];
      wp_d     = wb_dat_i[CTRL_WP];
      ede_d    = wb_dat_i[CTRL_EDE];
      if (!enable_q) begin
        cfg_d = wb_dat_i[CTRL_CFG +: 3];
      end
    end
    if (wbWr && wb_adr_i == ADR_PTRH) begin
      ptrHigh_d = wb_dat_i[7:0];
    end
    if (wbWr && wb_adr_i == ADR_STAT && wb_dat_i[STAT_EOD]) begin
      eod_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (memWe_q && lastByte) begin
      eod_d = 1'b1;
    end
    if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          wbDat_d[CTRL_EN]       = enable_q;
          wbDat_d[CTRL_CFG +: 3] = cfg_q;
          wbDat_d[CTRL_WP]       = wp_q;
          wbDat_d[CTRL_EDE]      = ede_q;
        end
        ADR_PTRH: wbDat_d[7:0] = ptrHigh_q;
        ADR_STAT: begin
          wbDat_d[STAT_EOD]        = eod_q;
          wbDat_d[STAT_HOST]       = hostMode_q;
          wbDat_d[STAT_BUSY]       = (state_q != ST_IDLE);
          wbDat_d[STAT_PTRLO +: 8] = ptrLow_q;
        end
        default: wbDat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q  <= 1'b0;
      cfg_q     <= CFG_RST;
      wp_q      <= 1'b0;
      ede_q     <= 1'b0;
      ptrHigh_q <= PTRH_RST;
      eod_q     <= 1'b0;
      wbAck_q   <= 1'b0;
      wbDat_q   <= 32'h0000_0000;
    end else begin
      enable_q  <= enable_d;
      cfg_q     <= cfg_d;
      wp_q      <= wp_d;
      ede_q     <= ede_d;
      ptrHigh_q <= ptrHigh_d;
      eod_q     <= eod_d;
      wbAck_q   <= wbAck_d;
      wbDat_q   <= wbDat_d;
    end
  end

  assign wb_ack_o     = wbAck_q;
  assign wb_dat_o     = wbDat_q;
  assign endOfDataIrq = eod_q & ede_q;

  // ****************************************************************
  // two-wire slave engine
  // ****************************************************************
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  shift_q, shift_d, pendData_q, pendData_d, pendAddr_q, pendAddr_d;
  logic        rw_q, rw_d, mAck_q, mAck_d, drive_q, drive_d;
  logic        pendValid_q, pendValid_d, memRe_q, memRe_d, launch;
  logic        cfgOk, hostEntry;
  logic [1:0]  hit;

  // reserved configs never enter; old-structure configs enter on first scl fall
  assign cfgOk     = ~(cfg_q[2] & cfg_q[0]);
  assign hostEntry = enable_q & ~hostMode_q & cfgOk & (cfg_q[0] | sclFall);
  assign hit       = ddc_match(cfg_q, shift_q[7:1]);

  always_comb begin
    state_d     = state_q;
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    rw_d        = rw_q;
    is256_d     = is256_q;
    mAck_d      = mAck_q;
    drive_d     = drive_q;
    ptrLow_d    = ptrLow_q;
    pendValid_d = pendValid_q;
    pendData_d  = pendData_q;
    pendAddr_d  = pendAddr_q;
    memRe_d     = 1'b0;
    launch      = 1'b0;
    hostMode_d  = enable_q & cfgOk & (hostMode_q | hostEntry);
    if (hostEntry) begin
      ptrLow_d = 8'h00;
    end
    if (!hostMode_q) begin
      state_d = ST_IDLE;
      drive_d = 1'b0;
    end else if (startDet) begin
      state_d  = ST_ADDR;
      bitCnt_d = 4'h0;
      drive_d  = 1'b0;
    end else if (stopDet) begin
      state_d     = ST_IDLE;
      drive_d     = 1'b0;
      launch      = pendValid_q & ~wp_q;
      pendValid_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: drive_d = 1'b0;
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaLvl};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == BYTE_BITS) begin
            bitCnt_d = 4'h0;
            drive_d  = 1'b1;
            if (state_q == ST_ADDR) begin
              if (!hit[1]) begin
                state_d = ST_IDLE;
                drive_d = 1'b0;
              end else begin
                rw_d    = shift_q[0];
                is256_d = hit[0];
                state_d = ST_ADDR_ACK;
              end
            end else if (state_q == ST_SUB) begin
              ptrLow_d = shift_q;
              state_d  = ST_SUB_ACK;
            end else begin
              // previous byte goes to ram while this one waits for the next byte or the stop
              launch      = pendValid_q & ~wp_q;
              pendValid_d = 1'b1;
              pendData_d  = shift_q;
              pendAddr_d  = ptrLow_q;
              ptrLow_d    = ddc_next_ptr(ptrLow_q, is256_q);
              state_d     = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclRise && rw_q) begin
            memRe_d  = 1'b1;
            ptrLow_d = ddc_next_ptr(ptrLow_q, is256_q);
          end else if (sclFall && rw_q) begin
            state_d  = ST_RDATA;
            drive_d  = ~shift_q[7];
            shift_d  = {shift_q[6:0], 1'b0};
            bitCnt_d = 4'h1;
          end else if (sclFall) begin
            state_d = ST_SUB;
            drive_d = 1'b0;
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            state_d = ST_WDATA;
            drive_d = 1'b0;
          end
        end
        ST_RDATA: begin
          if (sclFall && bitCnt_q < BYTE_BITS) begin
            drive_d  = ~shift_q[7];
            shift_d  = {shift_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall) begin
            drive_d = 1'b0;
            state_d = ST_RACK;
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            mAck_d = ~sdaLvl;
            if (!sdaLvl) begin
              memRe_d  = 1'b1;
              ptrLow_d = ddc_next_ptr(ptrLow_q, is256_q);
            end
          end else if (sclFall && mAck_q) begin
            state_d  = ST_RDATA;
            drive_d  = ~shift_q[7];
            shift_d  = {shift_q[6:0], 1'b0};
            bitCnt_d = 4'h1;
          end else if (sclFall) begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // fetched byte lands one cycle after the read strobe
    if (memRe_q) begin
      shift_d = memRdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      rw_q        <= 1'b0;
      is256_q     <= 1'b0;
      mAck_q      <= 1'b0;
      drive_q     <= 1'b0;
      hostMode_q  <= 1'b0;
      ptrLow_q    <= 8'h00;
      pendValid_q <= 1'b0;
      pendData_q  <= 8'h00;
      pendAddr_q  <= 8'h00;
      memRe_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      bitCnt_q    <= bitCnt_d;
      shift_q     <= shift_d;
      rw_q        <= rw_d;
      is256_q     <= is256_d;
      mAck_q      <= mAck_d;
      drive_q     <= drive_d;
      hostMode_q  <= hostMode_d;
      ptrLow_q    <= ptrLow_d;
      pendValid_q <= pendValid_d;
      pendData_q  <= pendData_d;
      pendAddr_q  <= pendAddr_d;
      memRe_q     <= memRe_d;
    end
  end

  // open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe  = drive_q;
  assign memRe  = memRe_q;

  // ****************************************************************
  // dma port, cycle stealing from the processor on ram writes, reads do not stall
  // ****************************************************************
  logic [7:0] memWdata_q, memWdata_d;
  logic [1:0] stall_q, stall_d;

  always_comb begin
    memWe_d    = launch;
    memWdata_d = launch ? pendData_q : memWdata_q;
    memAddr_d  = memAddr_q;
    if (launch) begin
      memAddr_d = {ddc_block(ptrHigh_q, cfg_q[1:0], is256_q), pendAddr_q};
    end else if (memRe_d) begin
      memAddr_d = {ddc_block(ptrHigh_q, cfg_q[1:0], is256_q), ptrLow_q};
    end
    stall_d = launch ? DMA_STALL : (stall_q != 2'h0) ? stall_q - 2'h1 : 2'h0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memWe_q    <= 1'b0;
      memWdata_q <= 8'h00;
      memAddr_q  <= 16'h0000;
      stall_q    <= 2'h0;
    end else begin
      memWe_q    <= memWe_d;
      memWdata_q <= memWdata_d;
      memAddr_q  <= memAddr_d;
      stall_q    <= stall_d;
    end
  end

  assign memWe    = memWe_q;
  assign memWdata = memWdata_q;
  assign memAddr  = memAddr_q;
  assign cpuStall = (stall_q != 2'h0);

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_sda_on_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sdaOe) |-> !sclLvl)
    else $error("sda driven while scl high");
  chk_ptr_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hostMode_q) |-> ptrLow_q == 8'h00)
    else $error("pointer not cleared on entry");
  chk_idle_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == ST_IDLE |-> !sdaOe)
    else $error("sda driven while idle");
  chk_nack_standby: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == ST_RACK && sclFall && !mAck_q && !startDet && !stopDet
    |=> state_q == ST_IDLE)
    else $error("no standby after master nack");
  chk_stop_launch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hostMode_q && stopDet && pendValid_q && !wp_q |=> memWe ##1 !memWe)
    else $error("stop did not launch one ram write");
  chk_stall_two: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memWe |-> cpuStall ##1 cpuStall ##1 !cpuStall)
    else $error("stall not two cycles");
  chk_wp_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memWe |-> !$past(wp_q))
    else $error("write while protected");
  chk_eod_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    memWe && lastByte |=> eod_q)
    else $error("end flag not set");
  chk_cfg_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(cfg_q) |-> !$past(enable_q))
    else $error("config changed while enabled");
  chk_block_lsb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (memWe || memRe) && cfg_q[1:0] == CFG_DUAL |-> memAddr[8] == ~is256_q)
    else $error("block lsb wrong in dual config");

  cov_write_flush: cover property (@(posedge ref_clk) disable iff (!rst_n)
    stopDet && pendValid_q ##1 memWe);
  cov_read_nack: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == ST_RACK && sclFall && !mAck_q);
  cov_seq_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == ST_RACK && sclFall && mAck_q);
  cov_eod: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(eod_q));

endmodule : ddc_edid_slave

/* design/ddc_line_sync.sv */
module ddc_line_sync
  import ddc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclLvl,
  output logic      sdaLvl,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startDet,
  output logic      stopDet
);

  // ****************************************************************
  // three-stage synchronisers with agreement filter
  // ****************************************************************
  logic [2:0] sclSync_q, sclSync_d;
  logic [2:0] sdaSync_q, sdaSync_d;
  logic       sclLvl_q, sclLvl_d, sdaLvl_q, sdaLvl_d;
  logic       sclRise_q, sclRise_d, sclFall_q, sclFall_d;
  logic       start_q, start_d, stop_q, stop_d;

  // a level only moves once stages two and three agree, stage one feeds stage two only
  always_comb begin
    sclSync_d = {sclSync_q[1:0], sclIn};
    sdaSync_d = {sdaSync_q[1:0], sdaIn};
    sclLvl_d  = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclLvl_q;
    sdaLvl_d  = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaLvl_q;
    sclRise_d = sclLvl_d & ~sclLvl_q;
    sclFall_d = ~sclLvl_d & sclLvl_q;
    // start and stop need scl high before and after the data change
    start_d   = sclLvl_q & sclLvl_d & sdaLvl_q & ~sdaLvl_d;
    stop_d    = sclLvl_q & sclLvl_d & ~sdaLvl_q & sdaLvl_d;
  end

  // idle bus is high on both lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclLvl_q  <= 1'b1;
      sdaLvl_q  <= 1'b1;
      sclRise_q <= 1'b0;
      sclFall_q <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
    end else begin
      sclSync_q <= sclSync_d;
      sdaSync_q <= sdaSync_d;
      sclLvl_q  <= sclLvl_d;
      sdaLvl_q  <= sdaLvl_d;
      sclRise_q <= sclRise_d;
      sclFall_q <= sclFall_d;
      start_q   <= start_d;
      stop_q    <= stop_d;
    end
  end

  assign sclLvl   = sclLvl_q;
  assign sdaLvl   = sdaLvl_q;
  assign sclRise  = sclRise_q;
  assign sclFall  = sclFall_q;
  assign startDet = start_q;
  assign stopDet  = stop_q;

  chk_start_scl_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    startDet |-> sclLvl && !sdaLvl)
    else $error("start flagged without scl high");

endmodule : ddc_line_sync

/* design/ddc_pkg.sv */
package ddc_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_PTRH    = 8'h04;
  localparam logic [7:0] ADR_STAT    = 8'h08;

  // channel control field positions
  localparam int         CTRL_EN     = 0;
  localparam int         CTRL_CFG    = 1;
  localparam int         CTRL_WP     = 4;
  localparam int         CTRL_EDE    = 5;

  // status field positions
  localparam int         STAT_EOD    = 0;
  localparam int         STAT_HOST   = 1;
  localparam int         STAT_BUSY   = 2;
  localparam int         STAT_PTRLO  = 8;

  // reset values
  localparam logic [2:0] CFG_RST     = 3'h0;
  localparam logic [7:0] PTRH_RST    = 8'h00;

  // ****************************************************************
  // protocol constants
  // ****************************************************************
  localparam logic [6:0] DEV_V1      = 7'h50;  // 128-byte structure pair
  localparam logic [6:0] DEV_V2      = 7'h51;  // 256-byte structure pair
  localparam logic [6:0] DEV_FP      = 7'h53;  // flat-panel pair
  localparam logic [1:0] CFG_DUAL    = 2'h2;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [1:0] DMA_STALL   = 2'h2;   // processor cycles lost per byte written

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } ddc_state_e;

  // device address decode: returns {hit, wide structure}
  function automatic logic [1:0] ddc_match(input logic [2:0] cfg, input logic [6:0] dev);
    case (cfg)
      3'h0, 3'h4: return {dev == DEV_V1, 1'b0};
      3'h1:       return {dev == DEV_V2, 1'b1};
      3'h2, 3'h6: return {(dev == DEV_V1) || (dev == DEV_V2), dev == DEV_V2};
      3'h3:       return {dev == DEV_FP, 1'b1};
      default:    return 2'h0;
    endcase
  endfunction : ddc_match

  // pointer step over the low 7 or 8 bits only
  function automatic logic [7:0] ddc_next_ptr(input logic [7:0] p, input logic wide);
    return wide ? p + 8'h01 : {p[7], p[6:0] + 7'h01};
  endfunction : ddc_next_ptr

  // block select, lsb forced apart when both structures coexist
  function automatic logic [7:0] ddc_block(input logic [7:0] h, input logic [1:0] cfgLow,
                                           input logic wide);
    return (cfgLow == CFG_DUAL) ? {h[7:1], ~wide} : h;
  endfunction : ddc_block

endpackage : ddc_pkg

/* tb/ddc_host_model.sv */
module ddc_host_model (
  input  wire logic ref_clk,
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // two-wire master, scl stands high between frames
  // ********
  localparam int HALF = 8;  // clocks per scl phase; 80 ns at the 10 ns clock, for synchroniser margin
  logic pull = 1'b0;
  initial scl = 1'b1;
  // pull-up: a released line reads high, never the last value
  assign sdaLine = ~(pull | sdaOe);
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : w
  // start, or repeated start from a low scl
  task automatic start();
    pull <= 1'b0;
    w(HALF - 3);
    scl <= 1'b1;
    w(HALF);
    pull <= 1'b1;
    w(HALF);
    scl <= 1'b0;
    w(3);
  endtask : start
  task automatic stop();
    pull <= 1'b1;
    w(HALF - 3);
    scl <= 1'b1;
    w(HALF);
    pull <= 1'b0;
    w(HALF);
  endtask : stop
  // sda moves only mid low phase; wire sampled late in high phase
  task automatic bitc(input logic v, output logic s);
    pull <= ~v;
    w(HALF - 3);
    scl <= 1'b1;
    w(HALF - 1);
    s = sdaLine;
    w(1);
    scl <= 1'b0;
    w(3);
  endtask : bitc
  task automatic pulse();
    scl <= 1'b0;
    w(HALF);
    scl <= 1'b1;
    w(HALF);
  endtask : pulse
  task automatic sendB(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitc(b[i], s);
    bitc(1'b1, s);
    ack = ~s;
  endtask : sendB
  // ack asks for more, nack ends the read
  task automatic recvB(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitc(1'b1, b[i]);
    bitc(~ackIt, s);
  endtask : recvB
endmodule : ddc_host_model

/* tb/test_ddc_edid_slave.sv */
module test_ddc_edid_slave
  import ddc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic [15:0] memAddr;
  logic [7:0]  memWdata, memRdata;
  logic        wb_ack_o, sclIn, sdaIn, sdaOut, sdaOe, memWe, memRe, cpuStall, irq, sclQ, oeQ;
  logic [7:0]  ram [65536];
  int          nErrors = 0, checksDone = 0, stallN = 0, weN = 0, badN = 0;

  ddc_edid_slave ddc_edid_slave_i (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclIn, .sdaIn, .sdaOut,
    .sdaOe, .memAddr, .memWdata, .memWe, .memRe, .memRdata, .cpuStall, .endOfDataIrq(irq));
  ddc_host_model host (.ref_clk, .sdaOe, .scl(sclIn), .sdaLine(sdaIn));

  always #5 ref_clk = ~ref_clk;
  function automatic logic [7:0] fill(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]};
  endfunction : fill
  // read data stands while memRe is high, the engine takes it at the next edge
  // seeded so blocks differ
  initial foreach (ram[i]) ram[i] = fill(16'(i));
  assign memRdata = (memRe === 1'b1) ? ram[memAddr] : 8'h00;
  always @(posedge ref_clk) begin
    if (memWe === 1'b1) ram[memAddr] <= memWdata;
  end
  // stall/dma tally and sda moving under a high scl
  always @(posedge ref_clk) begin
    if (cpuStall === 1'b1) stallN++;
    if (memWe === 1'b1) weN++;
    if (sclIn && sclQ && sdaOe !== oeQ) badN++;
    sclQ = sclIn;
    oeQ = sdaOe;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic testDone();
    if (nErrors == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : testDone
  // ********
  // bus helpers
  // ********
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 100);
    rd = wb_dat_o;
    if (n >= 100) nErrors++;
    if (n >= 100) testDone();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // end-of-data irq enable always set
  task automatic ctl(input logic [2:0] cfg, input logic en, wp);
    wb(1'b1, ADR_CTRL, 32'(en) | 32'(cfg) << CTRL_CFG | 32'(wp) << CTRL_WP | 32'h1 << CTRL_EDE);
  endtask : ctl
  task automatic hWrite(input logic [7:0] dev, sub, input logic [7:0] d[$]);
    logic a;
    host.start();
    host.sendB(dev, a);
    check("dev ack", a, 1);
    host.sendB(sub, a);
    check("sub ack", a, 1);
    foreach (d[i]) begin
      host.sendB(d[i], a);
      check("data ack", a, 1);
    end
    host.stop();
    host.w(4);
  endtask : hWrite
  task automatic hRead(input logic [7:0] dev, input logic [7:0] e[$]);
    logic       a;
    logic [7:0] b;
    host.start();
    host.sendB(dev, a);
    check("read dev ack", a, 1);
    foreach (e[i]) begin
      host.recvB(i != e.size() - 1, b);
      check("read byte", b, e[i]);
    end
    host.stop();
  endtask : hRead
  // ********
  // scenarios
  // ********
  task automatic testRegs();
    logic [7:0] adrs [4] = '{ADR_CTRL, ADR_PTRH, ADR_STAT, 8'h0c};
    foreach (adrs[i]) begin
      wb(1'b0, adrs[i], 32'h0);
      check("reset value", rd, 0);
    end
    wb(1'b1, ADR_PTRH, 32'h12);
    wb(1'b0, ADR_PTRH, 32'h0);
    check("ptr high", rd, 32'h12);
  endtask : testRegs
  task automatic testMap();
    logic [2:0] exp [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h0, 3'h3, 3'h0};
    logic [6:0] dv [3] = '{DEV_V1, DEV_V2, DEV_FP};
    logic       a;
    // reserved configs 101 and 111 must stay out of host mode and answer nothing
    for (int c = 0; c < 8; c++) begin
      ctl(3'h0, 1'b0, 1'b0);
      ctl(c[2:0], 1'b1, 1'b0);
      host.pulse();
      wb(1'b0, ADR_STAT, 32'h0);
      check("host mode", rd[STAT_HOST], c != 5 && c != 7);
      for (int d = 0; d < 3; d++) begin
        host.start();
        host.sendB({dv[d], 1'b0}, a);
        host.stop();
        check("address ack", a, exp[c][d]);
      end
    end
  endtask : testMap
  task automatic testWrite();
    ctl(3'h0, 1'b0, 1'b0);
    ctl(3'h1, 1'b1, 1'b0);
    hWrite(8'ha2, 8'hfe, {8'h11, 8'h22, 8'h33});
    check("ram fe", ram[16'h12fe], 8'h11);
    check("ram ff", ram[16'h12ff], 8'h22);
    check("ram wrap", ram[16'h1200], 8'h33);
    check("dma count", weN, 3);
    check("stall count", stallN, 6);
    check("eod irq", irq, 1);
    wb(1'b1, ADR_STAT, 32'h1);
    check("eod cleared", irq, 0);
    ctl(3'h1, 1'b1, 1'b1);
    hWrite(8'ha2, 8'h10, {8'h99});
    check("protected", ram[16'h1210], fill(16'h1210));
    check("no dma", weN, 3);
  endtask : testWrite
  task automatic testRead();
    logic a;
    host.start();
    host.sendB(8'ha2, a);
    host.sendB(8'hff, a);
    hRead(8'ha3, {8'h22, 8'h33});
    wb(1'b0, ADR_STAT, 32'h0);
    check("standby", rd[STAT_BUSY], 0);
    hRead(8'ha3, {fill(16'h1201)});
  endtask : testRead
  task automatic testDual();
    ctl(3'h0, 1'b0, 1'b0);
    ctl(3'h2, 1'b1, 1'b0);
    host.pulse();
    ctl(3'h3, 1'b1, 1'b0);
    wb(1'b0, ADR_CTRL, 32'h0);
    check("cfg locked", rd[3:1], 3'h2);
    hRead(8'ha1, {fill(16'h1300)});
    hWrite(8'ha0, 8'h7f, {8'h44, 8'h55});
    check("ram 7f", ram[16'h137f], 8'h44);
    check("wrap 7f", ram[16'h1300], 8'h55);
    hRead(8'ha3, {fill(16'h1201)});
  endtask : testDual
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    testRegs();
    testMap();
    testWrite();
    testRead();
    testDual();
    check("sda steady", badN, 0);
    check("sda pulls low only", sdaOut, 0);
    testDone();
  end
  // watchdog, well past the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    nErrors++;
    testDone();
  end
endmodule : test_ddc_edid_slave
